// ---- design/cfg_base_pkg.sv ----
// Constants for the configuration-port base relocation register bank
//
// Notes on behaviour
// [RL1] Registers reachable only in configuration state with select index equal to their index.
// [RL2] Three 8-bit read/write test-control registers, all bits reserved, reset to 0x00.
// [RL3] Host software must never activate test modes; they may misbehave.
// [RL4] Low base register holds base bits 7..0; high register bits 2..0 hold 10..8.
// [RL5] Port access decodes only when host address bits 15..11 are all zero.
// [RL6] Base is even: low register bit 0 reads zero, cannot be written.
// [RL7] Power-on and hard reset load low base 0x2E or 0x4E by strap, high 0x00.
// [RL8] Host writes the new low byte first, then the high base register.
// [RL9] Writing the high register makes the decoder use stored low plus written high.
// [RL10] High base register bits 7..3 read zero; writes to them are ignored.
// [RL11] Index 0x14 is reserved; its value after power-up is undefined.
// [RL12] Base is the index port, base plus one the data port; compare bits 10..1.
package cfg_base_pkg;
    localparam logic [7:0] IDX_TEST_CONTROL_A = 8'h0f;
    localparam logic [7:0] IDX_TEST_CONTROL_B = 8'h10;
    localparam logic [7:0] IDX_TEST_CONTROL_C = 8'h11;
    localparam logic [7:0] IDX_BASE_LOW       = 8'h12;
    localparam logic [7:0] IDX_BASE_HIGH      = 8'h13;
    localparam logic [7:0] IDX_RESERVED_14    = 8'h14;
    localparam logic [7:0] RST_TEST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_BASE_LOW_S0    = 8'h2e;
    localparam logic [7:0] RST_BASE_LOW_S1    = 8'h4e;
    localparam logic [7:0] RST_BASE_HIGH      = 8'h00;
    localparam logic [7:0] MASK_BASE_LOW      = 8'hfe;
    localparam logic [7:0] MASK_BASE_HIGH     = 8'h07;
    localparam logic [7:0] RESERVED_READ      = 8'h00;
    localparam logic [1:0] SYNC_FILL_EDGES    = 2'h3;
endpackage : cfg_base_pkg

// ---- design/config_port_base_relocation.sv ----
// Configuration-port base relocation registers and host port decoder
`timescale 1ns/1ps
module config_port_base_relocation
    import cfg_base_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // Hard reset (synchronous, same clock) and strap pin
    input  wire logic        i_hard_reset,
    input  wire logic        i_base_strap_select,
    // Configuration unit access
    input  wire logic        i_config_state,
    input  wire logic [7:0]  i_config_select_index,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_hit,
    // Host I/O address decode
    input  wire logic [15:0] i_io_addr,
    output logic             o_index_port_hit,
    output logic             o_data_port_hit,
    // Active base for observation
    output logic      [10:0] o_config_base
);

////////////////////////////////////////////////////////////////////////////////
typedef struct packed {
    logic [2:0]  strap_sync;
    logic        strap;
    logic [1:0]  fill;
    logic        load_pending;
    logic [7:0]  test_a;
    logic [7:0]  test_b;
    logic [7:0]  test_c;
    logic [7:0]  base_low;
    logic [7:0]  base_high;
    logic [10:0] active_base;
    logic [7:0]  rdata;
    logic        hit;
} state_s;

state_s cur;
state_s next_cur;

logic sel_a;
logic sel_b;
logic sel_c;
logic sel_low;
logic sel_high;
logic sel_res;
logic [7:0] strap_low;
logic       upper_zero;
logic       base_match;

////////////////////////////////////////////////////////////////////////////////
always_comb
begin
    next_cur  = cur;
    // Strap is off-domain: count a change once stages two and three agree
    next_cur.strap_sync = {cur.strap_sync[1:0], i_base_strap_select};
    if (cur.strap_sync[1] == cur.strap_sync[2])
    begin
        next_cur.strap = cur.strap_sync[2];
    end
    // Stages start at zero, so agreement means nothing until the pipe has filled
    if (cur.fill != SYNC_FILL_EDGES)
    begin
        next_cur.fill = 2'(cur.fill + 2'h1);
    end
    strap_low = next_cur.strap ? RST_BASE_LOW_S1 : RST_BASE_LOW_S0;
    sel_a    = i_config_state && (i_config_select_index == IDX_TEST_CONTROL_A); // RL1
    sel_b    = i_config_state && (i_config_select_index == IDX_TEST_CONTROL_B); // RL1
    sel_c    = i_config_state && (i_config_select_index == IDX_TEST_CONTROL_C); // RL1
    sel_low  = i_config_state && (i_config_select_index == IDX_BASE_LOW);       // RL1
    sel_high = i_config_state && (i_config_select_index == IDX_BASE_HIGH);      // RL1
    sel_res  = i_config_state && (i_config_select_index == IDX_RESERVED_14);    // RL11
    next_cur.hit = 1'b0;
    if (cur.load_pending || i_hard_reset)
    begin
        // Strap sampled after reset release, so a settled pin sets the base
        next_cur.load_pending = cur.load_pending &&
                                ((cur.fill != SYNC_FILL_EDGES) ||
                                 (cur.strap_sync[1] != cur.strap_sync[2]));
        next_cur.base_low     = strap_low & MASK_BASE_LOW;                     // RL7
        next_cur.base_high    = RST_BASE_HIGH;                                 // RL7
        next_cur.active_base  = {RST_BASE_HIGH[2:0], strap_low & MASK_BASE_LOW}; // RL7
        next_cur.rdata        = RESERVED_READ;
    end
    else
    begin
        if (i_wr)
        begin
            if (sel_a)
            begin
                next_cur.test_a = i_wdata; // RL2
            end
            if (sel_b)
            begin
                next_cur.test_b = i_wdata; // RL2
            end
            if (sel_c)
            begin
                next_cur.test_c = i_wdata; // RL2
            end
            if (sel_low)
            begin
                // Stored only; the decoder keeps the old base until a high write
                next_cur.base_low = i_wdata & MASK_BASE_LOW; // RL6
            end
            if (sel_high)
            begin
                next_cur.base_high   = i_wdata & MASK_BASE_HIGH;                // RL10
                next_cur.active_base = {i_wdata[2:0], cur.base_low};            // RL9 RL4
            end
        end
        if (i_rd)
        begin
            if (i_config_state)
            begin
                case (i_config_select_index)
                    IDX_TEST_CONTROL_A: next_cur.rdata = cur.test_a;    // RL2
                    IDX_TEST_CONTROL_B: next_cur.rdata = cur.test_b;    // RL2
                    IDX_TEST_CONTROL_C: next_cur.rdata = cur.test_c;    // RL2
                    IDX_BASE_LOW:       next_cur.rdata = cur.base_low;  // RL6
                    IDX_BASE_HIGH:      next_cur.rdata = cur.base_high; // RL10
                    default:            next_cur.rdata = RESERVED_READ; // RL11
                endcase
            end
            else
            begin
                // Outside configuration state nothing here answers
                next_cur.rdata = RESERVED_READ; // RL1
            end
        end
        next_cur.hit = (i_rd || i_wr) && (sel_a || sel_b || sel_c || sel_low || sel_high || sel_res);
    end
end

always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        cur.strap_sync   <= 3'h0;
        cur.strap        <= 1'b0;
        cur.fill         <= 2'h0;
        cur.load_pending <= 1'b1;
        cur.test_a       <= RST_TEST_CONTROL; // RL2
        cur.test_b       <= RST_TEST_CONTROL; // RL2
        cur.test_c       <= RST_TEST_CONTROL; // RL2
        cur.base_low     <= RST_BASE_LOW_S0;
        cur.base_high    <= RST_BASE_HIGH;
        cur.active_base  <= {RST_BASE_HIGH[2:0], RST_BASE_LOW_S0};
        cur.rdata        <= RESERVED_READ;
        cur.hit          <= 1'b0;
    end
    else if (i_ce)
    begin
        cur <= next_cur;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Decode is combinational so the host cycle sees the match immediately
always_comb
begin
    upper_zero = (i_io_addr[15:11] == 5'h00);                 // RL5
    base_match = (i_io_addr[10:1] == cur.active_base[10:1]);  // RL12
end

assign o_index_port_hit = upper_zero && base_match && !i_io_addr[0]; // RL12
assign o_data_port_hit  = upper_zero && base_match && i_io_addr[0];  // RL12
assign o_rdata          = cur.rdata;
assign o_hit            = cur.hit;
assign o_config_base    = cur.active_base;

endmodule : config_port_base_relocation

// ---- verification/lpc_host_model.sv ----
// Host model issuing configuration and I/O cycles
`timescale 1ns/1ps
module lpc_host_model (
    input  wire logic        i_clk,
    output logic             o_cs, o_wr, o_rd,
    output logic [7:0]       o_idx, o_wd,
    output logic [15:0]      o_addr
);
    initial {o_cs, o_wr, o_rd, o_idx, o_wd, o_addr} = '0;
    // One-cycle pulse; data inverted once released so stale values never match
    task acc(input logic c, w, input logic [7:0] i, d);
        @(negedge i_clk);
        {o_cs, o_idx, o_wd, o_wr, o_rd} = {c, i, d, w, !w};
        @(negedge i_clk);
        {o_wr, o_rd, o_wd} = {2'b00, ~d};
    endtask : acc
    task probe(input logic [15:0] a);
        @(negedge i_clk);
        o_addr = a;
        #10;
    endtask : probe
endmodule : lpc_host_model

// ---- verification/cpbr_monitor.sv ----
// Checker for the base relocation register bank
`timescale 1ns/1ps
module cpbr_monitor (
    input wire logic        i_clk, i_rst_n, i_ce, i_hard_reset, i_base_strap_select,
    input wire logic        i_config_state, i_wr, i_rd, o_hit, o_index_port_hit, o_data_port_hit,
    input wire logic [7:0]  i_config_select_index, i_wdata, o_rdata,
    input wire logic [15:0] i_io_addr,
    input wire logic [10:0] o_config_base
);
    logic       go;
    logic [7:0] ix;
    assign go = i_ce && i_config_state && !i_hard_reset;
    assign ix = i_config_select_index;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    hit_cause_a: assert property (o_hit |-> $past(go && (i_wr || i_rd) && ix >= 8'h0f && ix <= 8'h14)) else $error("hit");
    out_state_a: assert property (i_ce && !i_config_state && (i_wr || i_rd) |=> !o_hit) else $error("state");
    even_base_a: assert property (o_config_base[0] == 1'b0) else $error("odd");
    index_port_a: assert property (o_index_port_hit == (i_io_addr == {5'h00, o_config_base})) else $error("ip");
    data_port_a: assert property (o_data_port_hit == (i_io_addr == {5'h00, o_config_base[10:1], 1'b1})) else $error("dp");
    high_read_a: assert property (go && i_rd && ix == 8'h13 |=> o_rdata[7:3] == 5'h00) else $error("hr");
    low_read_a: assert property (go && i_rd && ix == 8'h12 |=> !o_rdata[0]) else $error("lr");
    rsvd_read_a: assert property (go && i_rd && ix == 8'h14 |=> o_rdata == 8'h00) else $error("rr");
    base_move_a: assert property (go && i_wr && ix == 8'h13 |=> o_config_base[10:8] == $past(i_wdata[2:0])) else $error("bm");
    low_hold_a: assert property (go && i_wr && ix == 8'h12 |=> $stable(o_config_base)) else $error("lh");
    cover property (go && i_wr && ix == 8'h13);
    cover property (o_data_port_hit);
    cover property (o_hit && o_rdata == 8'h00);
endmodule : cpbr_monitor
bind config_port_base_relocation cpbr_monitor u_mon (.*);

// ---- verification/test_config_port_base_relocation.sv ----
// Self-checking bench for the base relocation register bank
`timescale 1ns/1ps
module test_config_port_base_relocation;
    logic        i_clk = 0, i_rst_n = 0, i_ce = 1, hrst = 0, strap = 0, cs, wr, rd, hit, ih, dh;
    logic [7:0]  idx, wd, rdata;
    logic [15:0] addr;
    logic [10:0] base;
    int          num_errors = 0, checks_done = 0;
    initial forever #50 i_clk = ~i_clk;
    lpc_host_model i_host (.i_clk(i_clk), .o_cs(cs), .o_wr(wr), .o_rd(rd), .o_idx(idx), .o_wd(wd), .o_addr(addr));
    config_port_base_relocation i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_hard_reset(hrst),
        .i_base_strap_select(strap), .i_config_state(cs), .i_config_select_index(idx), .i_wr(wr), .i_rd(rd),
        .i_wdata(wd), .o_rdata(rdata), .o_hit(hit), .i_io_addr(addr), .o_index_port_hit(ih),
        .o_data_port_hit(dh), .o_config_base(base));
    ////////////////////////////////////////////////////////////////
    task ck(input string n, input logic [10:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : ck
    task rst(input logic s);
        {strap, i_rst_n} = {s, 1'b0};
        repeat (2) @(negedge i_clk);
        i_rst_n = 1;
        repeat (5) @(negedge i_clk);
        ck("base", base, s ? 11'h04e : 11'h02e);
        for (int i = 15; i <= 19; i++)
        begin
            i_host.acc(1, 0, 8'(i), 8'h00);
            ck("reset", {2'b00, hit, rdata}, i == 18 ? {3'h1, s ? 8'h4e : 8'h2e} : 11'h100);
        end
        $display("rst done");
    endtask : rst
    task t_test;
        for (int i = 15; i <= 18; i++)
            i_host.acc(i < 18, 1, 8'(i), 8'(i * 3));
        ck("hit", hit, 11'h000);
        for (int i = 15; i <= 17; i++)
        begin
            i_host.acc(1, 0, 8'(i), 8'h00);
            ck("test", rdata, 11'(i * 3));
        end
        for (int i = 15; i <= 17; i++)
            i_host.acc(1, 1, 8'(i), 8'h00);
        i_host.acc(1, 0, 8'h0f, 8'h00);
        ck("clear", rdata, 11'h000);
        $display("t_test done");
    endtask : t_test
    task t_move;
        i_host.acc(1, 1, 8'h12, 8'h61);
        ck("base", base, 11'h02e);
        i_host.acc(1, 0, 8'h12, 8'h00);
        ck("low", rdata, 11'h060);
        i_host.acc(1, 1, 8'h13, 8'hff);
        ck("base", base, 11'h760);
        i_host.acc(1, 0, 8'h13, 8'h00);
        ck("high", rdata, 11'h007);
        i_host.acc(1, 0, 8'h14, 8'h00);
        ck("rsvd", {2'b00, hit, rdata}, 11'h100);
        i_host.probe(16'h0760);
        ck("idx", {ih, dh}, 11'h002);
        i_host.probe(16'h0761);
        ck("dat", {ih, dh}, 11'h001);
        i_host.probe(16'h8760);
        ck("hi", {ih, dh}, 11'h000);
        $display("t_move done");
    endtask : t_move
    task t_hard;
        strap = 1;
        repeat (4) @(negedge i_clk);
        hrst = 1;
        @(negedge i_clk);
        hrst = 0;
        ck("base", base, 11'h04e);
        $display("t_hard done");
    endtask : t_hard
    task test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    initial
    begin
        rst(0);
        t_test;
        t_move;
        t_hard;
        rst(1);
        test_done;
    end
endmodule : test_config_port_base_relocation
